// *** apmsc_pkg.sv ***
// Shared constants for the converter mode and power-state control block
package apmsc_pkg;
   localparam int unsigned REF_CLK_PERIOD_NS = 40;
   localparam int unsigned POWER_UP_TIME_NS = 1000;
   localparam int unsigned POWER_UP_CYCLES =
      (POWER_UP_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int unsigned RESULT_WIDTH = 12;
   localparam logic [4:0] EDGE_GLITCH_GUARD = 5'h02;
   localparam logic [4:0] EDGE_KEEP_POWER = 5'h0A;
   localparam logic [4:0] EDGE_BACK_TO_TRACK = 5'h0D;
   localparam logic [4:0] EDGE_FRAME_DONE = 5'h10;
   localparam logic [4:0] EDGE_LOAD_RESULT = 5'h03;
   localparam logic [4:0] EDGE_COUNT_RESET = 5'h00;
   // Synchroniser bit positions for link flags
   localparam int unsigned SY_FRAME_N = 0;
   localparam int unsigned SY_GE2 = 1;
   localparam int unsigned SY_GE10 = 2;
   localparam int unsigned SY_GE16 = 3;
   localparam int unsigned SY_TRACK13 = 4;
   localparam int unsigned SY_FIRST_EDGE = 5;
   localparam int unsigned SY_WIDTH = 6;
   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_DOWN = 2'b01,
      ST_WAKING = 2'b10
   } apmsc_state_t;
endpackage : apmsc_pkg

// *** apmsc_ctrl.sv ***
// Mode, power-state and serial result control of a sampling converter
`timescale 1ns/100ps
`default_nettype none
module apmsc_ctrl
   import apmsc_pkg::*;
#(
   parameter int unsigned PU_CYCLES = apmsc_pkg::POWER_UP_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic serial_clk_i,
   input wire logic frame_n_i,
   input wire logic [apmsc_pkg::RESULT_WIDTH-1:0] result_i,
   output logic serial_result_out_o,
   output logic serial_result_out_oe_o,
   output logic analog_on_o,
   output logic track_o,
   output logic powered_up_o,
   output logic conv_done_o,
   output logic conv_abort_o
);
   import apmsc_pkg::*;

   // Power-up timer is eight bits wide
   if (PU_CYCLES < 1 || PU_CYCLES > 255) begin : g_bad_pu_cycles
      $error("PU_CYCLES out of range");
   end

   // Link side: serial clock stops between frames, so frame high clears it
   logic link_rst;
   logic [4:0] cnt_ff, nxt_cnt;
   logic ge2_ff, ge10_ff, ge16_ff;
   logic [RESULT_WIDTH:0] shift_ff, nxt_shift;
   logic [RESULT_WIDTH-1:0] res_s1_ff, res_s2_ff;
   logic track13_ff, first_edge_ff;
   logic nxt_ge2, nxt_ge10, nxt_ge16, nxt_track13;

   assign link_rst = frame_n_i | ~rstn_i;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (cnt_ff < EDGE_FRAME_DONE) begin
         nxt_cnt = cnt_ff + 5'h01;
      end
      nxt_shift = {shift_ff[RESULT_WIDTH-1:0], 1'b0};
      if (nxt_cnt == EDGE_LOAD_RESULT) begin
         // Leading zero stays on the line one more edge
         nxt_shift = {1'b0, res_s2_ff};
      end
      nxt_ge2 = nxt_cnt >= EDGE_GLITCH_GUARD;
      nxt_ge10 = nxt_cnt >= EDGE_KEEP_POWER;
      nxt_ge16 = nxt_cnt >= EDGE_FRAME_DONE;
      nxt_track13 = cnt_ff >= EDGE_BACK_TO_TRACK;
   end

   always_ff @(negedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         cnt_ff <= EDGE_COUNT_RESET;
         ge2_ff <= 1'b0;
         ge10_ff <= 1'b0;
         ge16_ff <= 1'b0;
         shift_ff <= '0;
         res_s1_ff <= '0;
         res_s2_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         ge2_ff <= nxt_ge2;
         ge10_ff <= nxt_ge10;
         ge16_ff <= nxt_ge16;
         shift_ff <= nxt_shift;
         res_s1_ff <= result_i;
         res_s2_ff <= res_s1_ff;
      end
   end

   always_ff @(posedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         track13_ff <= 1'b0;
         first_edge_ff <= 1'b0;
      end else begin
         track13_ff <= nxt_track13;
         first_edge_ff <= 1'b1;
      end
   end

   // Enable must rise with the frame itself, before any serial clock edge
   assign serial_result_out_o = shift_ff[RESULT_WIDTH];
   assign serial_result_out_oe_o = ~link_rst & ~ge16_ff;

   // System side: two-flop synchronisers for link levels
   logic [SY_WIDTH-1:0] sy1_ff, sy2_ff, link_lvl;
   assign link_lvl = {first_edge_ff, track13_ff, ge16_ff, ge10_ff, ge2_ff,
      frame_n_i};

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sy1_ff <= {{(SY_WIDTH-1){1'b0}}, 1'b1};
         sy2_ff <= {{(SY_WIDTH-1){1'b0}}, 1'b1};
      end else begin
         sy1_ff <= link_lvl;
         sy2_ff <= sy1_ff;
      end
   end

   apmsc_state_t st_ff, nxt_st;
   logic frame_n_d_ff, nxt_frame_n_d;
   logic l2_ff, l10_ff, l16_ff, nxt_l2, nxt_l10, nxt_l16;
   logic [7:0] pu_cnt_ff, nxt_pu_cnt;
   logic on_ff, nxt_on, trk_ff, nxt_trk, rdy_ff, nxt_rdy;
   logic done_ff, nxt_done, abort_ff, nxt_abort;
   logic fr_fall, fr_rise, g2, g10, g16;

   always_comb begin
      fr_fall = frame_n_d_ff & ~sy2_ff[SY_FRAME_N];
      fr_rise = ~frame_n_d_ff & sy2_ff[SY_FRAME_N];
      // Flags clear with the frame; latched copies survive the race
      g2 = l2_ff | sy2_ff[SY_GE2];
      g10 = l10_ff | sy2_ff[SY_GE10];
      g16 = l16_ff | sy2_ff[SY_GE16];
      nxt_frame_n_d = sy2_ff[SY_FRAME_N];
      nxt_l2 = fr_rise ? 1'b0 : g2;
      nxt_l10 = fr_rise ? 1'b0 : g10;
      nxt_l16 = fr_rise ? 1'b0 : g16;
      nxt_st = st_ff;
      nxt_on = on_ff;
      nxt_done = 1'b0;
      nxt_abort = 1'b0;
      nxt_pu_cnt = pu_cnt_ff;
      unique case (st_ff)
         ST_NORMAL: begin
            if (fr_rise) begin
               nxt_done = g16;
               nxt_abort = ~g16;
               if (g2 && !g10) begin
                  nxt_st = ST_DOWN;
                  nxt_on = 1'b0;
               end
               // Below edge 2 or from edge 10 on the mode is kept
            end
         end
         ST_DOWN: begin
            if (fr_fall) begin
               nxt_st = ST_WAKING;
               nxt_on = 1'b1;
            end
         end
         ST_WAKING: begin
            if (fr_rise) begin
               nxt_abort = 1'b1;
               if (g10) begin
                  nxt_st = ST_NORMAL;
               end else begin
                  nxt_st = ST_DOWN;
                  nxt_on = 1'b0;
               end
            end
         end
         default: begin
            nxt_st = ST_NORMAL;
         end
      endcase
      if (!nxt_on) begin
         nxt_pu_cnt = 8'h00;
      end else if (pu_cnt_ff < 8'(PU_CYCLES)) begin
         nxt_pu_cnt = pu_cnt_ff + 8'h01;
      end
      nxt_rdy = nxt_on && (nxt_pu_cnt >= 8'(PU_CYCLES));
      if (nxt_st == ST_DOWN) begin
         nxt_trk = 1'b0;
      end else if (sy2_ff[SY_FRAME_N]) begin
         nxt_trk = 1'b1;
      end else if (st_ff == ST_WAKING) begin
         nxt_trk = sy2_ff[SY_FIRST_EDGE];
      end else begin
         nxt_trk = sy2_ff[SY_TRACK13];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= ST_NORMAL;
         frame_n_d_ff <= 1'b1;
         l2_ff <= 1'b0;
         l10_ff <= 1'b0;
         l16_ff <= 1'b0;
         pu_cnt_ff <= 8'h00;
         on_ff <= 1'b1;
         trk_ff <= 1'b1;
         rdy_ff <= 1'b0;
         done_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         frame_n_d_ff <= nxt_frame_n_d;
         l2_ff <= nxt_l2;
         l10_ff <= nxt_l10;
         l16_ff <= nxt_l16;
         pu_cnt_ff <= nxt_pu_cnt;
         on_ff <= nxt_on;
         trk_ff <= nxt_trk;
         rdy_ff <= nxt_rdy;
         done_ff <= nxt_done;
         abort_ff <= nxt_abort;
      end
   end

   assign analog_on_o = on_ff;
   assign track_o = trk_ff;
   assign powered_up_o = rdy_ff;
   assign conv_done_o = done_ff;
   assign conv_abort_o = abort_ff;
endmodule : apmsc_ctrl
`default_nettype wire

// *** apmsc_assertions.sv ***
// Port checker for the converter mode control block
`timescale 1ns/100ps
`default_nettype none
module apmsc_assertions (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic frame_n_i,
   input wire logic serial_result_out_oe_o,
   input wire logic analog_on_o,
   input wire logic track_o,
   input wire logic powered_up_o,
   input wire logic conv_done_o,
   input wire logic conv_abort_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_frame_fall; frame_n_i ##1 !frame_n_i; endsequence
   property p_float; frame_n_i |-> !serial_result_out_oe_o; endproperty
   a_float: assert property (p_float) else $error("oe high");
   property p_done; conv_done_o |=> !conv_done_o; endproperty
   a_done: assert property (p_done) else $error("long done");
   property p_abort; conv_abort_o |=> !conv_abort_o; endproperty
   a_abort: assert property (p_abort) else $error("long abort");
   property p_down; !analog_on_o |-> !track_o && !powered_up_o; endproperty
   a_down: assert property (p_down) else $error("track in down");
   property p_stay; !analog_on_o && frame_n_i |=> !analog_on_o; endproperty
   a_stay: assert property (p_stay) else $error("woke idle");
   property p_hold; s_frame_fall |-> ##[1:4] !track_o; endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_wake; $rose(analog_on_o) |-> !powered_up_o [*2]; endproperty
   a_wake: assert property (p_wake) else $error("early power");
   property p_fin; conv_done_o |-> frame_n_i && analog_on_o; endproperty
   a_fin: assert property (p_fin) else $error("bad done");
endmodule : apmsc_assertions
bind apmsc_ctrl apmsc_assertions i_chk (.ref_clk_i, .rstn_i, .frame_n_i,
   .serial_result_out_oe_o, .analog_on_o, .track_o, .powered_up_o,
   .conv_done_o, .conv_abort_o);
`default_nettype wire

// *** apmsc_host.sv ***
// Host serial master model: frames, clock bursts, bit capture
`timescale 1ns/100ps
`default_nettype none
module apmsc_host (
   output logic serial_clk_o,
   output logic frame_n_o,
   input wire logic data_i,
   input wire logic oe_i
);
   logic [15:0] word;
   logic oe_late;
   initial begin
      serial_clk_o = 1'b1; // Parked high, still outside frames
      frame_n_o = 1'b1;
   end
   task automatic run(input int n);
      word = 16'h0000;
      frame_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         #6;
         word = {word[14:0], (oe_i === 1'b1) ? data_i : 1'bx};
         serial_clk_o = 1'b0;
         #6;
         serial_clk_o = 1'b1;
      end
      // Long low tail so the system side sees every frame
      #120;
      oe_late = oe_i;
      frame_n_o = 1'b1;
   endtask : run
endmodule : apmsc_host
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the converter mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import apmsc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [RESULT_WIDTH-1:0] result_i = '0;
   logic sclk, frame_n, sdo, sdo_oe, analog_on, track, pwr, done, abort;
   int failures = 0, checked = 0, cycles = 0, n_done, n_abort;
   int seed = 32'h5ce67456;
   int st = 0, prev, n;
   int plan[$] = '{16, 12, 0, 1, 16, 2, 9, 5, 8, 10, 16, 16, 3, 15};
   always #20 ref_clk_i = ~ref_clk_i;
   apmsc_ctrl #(.PU_CYCLES(POWER_UP_CYCLES)) i_dut (.ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i), .serial_clk_i(sclk), .frame_n_i(frame_n),
      .result_i(result_i), .serial_result_out_o(sdo),
      .serial_result_out_oe_o(sdo_oe), .analog_on_o(analog_on),
      .track_o(track), .powered_up_o(pwr), .conv_done_o(done),
      .conv_abort_o(abort));
   apmsc_host i_host (.serial_clk_o(sclk), .frame_n_o(frame_n),
      .data_i(sdo), .oe_i(sdo_oe));
   always @(posedge ref_clk_i) begin
      cycles++;
      if (done === 1'b1) n_done++;
      if (abort === 1'b1) n_abort++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic cmp_lvl(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t level %b exp %b", $time, got, exp);
      end
   endtask : cmp_lvl
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t value %h exp %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (8) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      repeat (30) @(negedge ref_clk_i);
      cmp_lvl(pwr, 1'b1);
      cmp_lvl(track, 1'b1);
      for (int i = 0; i < 10; i++) begin
         plan.push_back($unsigned($random(seed)) % 17);
      end
      foreach (plan[i]) begin
         n = plan[i];
         result_i = RESULT_WIDTH'($random(seed));
         n_done = 0;
         n_abort = 0;
         i_host.run(n);
         // Quiet interval plus settling of the mode decision
         repeat (30) @(negedge ref_clk_i);
         prev = st;
         if (st == 0) st = (n >= 2 && n <= 9) ? 1 : 0;
         else st = (n >= 10) ? 0 : 1;
         if (prev == 0 && n == 16) begin
            cmp_word(i_host.word, {4'h0, result_i});
         end
         cmp_lvl(i_host.oe_late, n < 16);
         cmp_word(16'(n_done), 16'(prev == 0 && n == 16));
         cmp_word(16'(n_abort), 16'(prev == 1 || n < 16));
         cmp_lvl(analog_on, st == 0);
         cmp_lvl(track, st == 0);
         cmp_lvl(pwr, st == 0);
      end
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
